/* rtl/usb_command_watchdog_map.vh */
// constants for the usb command watchdog
`ifndef USB_COMMAND_WATCHDOG_MAP_VH
`define USB_COMMAND_WATCHDOG_MAP_VH
`define CMD_SYNC_BYTE 8'hF8
`define CMD_WORD_COUNT 8'h05
`define CMD_EXT_CODE 8'h09
`define POS_HEADER_SUM 0
`define POS_SYNC 1
`define POS_WORDS 2
`define POS_EXT 3
`define POS_BODY_LO 4
`define POS_BODY_HI 5
`define POS_UPDATE_SELECT 6
`define POS_OPTIONS 7
`define POS_LIMIT_LO 8
`define POS_LIMIT_HI 9
`define POS_LINE_CFG 10
`define CMD_LENGTH 16
`define BIT_UPDATE_WRITE 0
`define BIT_OPT_RESET 5
`define BIT_OPT_LINE 4
`define BIT_LINE_LEVEL 7
`define LINE_INDEX_MSB 4
`define LINE_INDEX_MAX 5'h13
`define LINE_COUNT 20
`define TICK_PERIOD_NS 1000000000
`define CLK_PERIOD_NS 100
`define ERR_NONE 8'h00
`define ERR_BAD_LINE 8'h01
`define SETTINGS_RESET 32'h0000_0000
`endif

/* rtl/second_tick.v */
// prescaler giving one pulse per tick period
`include "usb_command_watchdog_map.vh"
`timescale 1ns/1ps
module second_tick #(
  parameter integer DIVIDE = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire ref_clk,
  input wire srst,
  input wire clear,
  output reg tick
);
  reg [31:0] count_reg;
  always @(posedge ref_clk)
  begin
    if (srst || clear)
    begin
      count_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (count_reg == DIVIDE - 1)
    begin
      count_reg <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule // second_tick

/* rtl/usb_command_watchdog.v */
// usb command watchdog: command parser, settings store and expiry actions
// Operation
// - command and reply header F8 05 09
// - counter runs only with nonzero options
// - any host transfer clears counter
// - outgoing stream packets never clear counter
// - reaching limit fires selected actions
// - counter advances about once per second
// - bit5 resets device, bit4 drives line
// - line config: level bit7, index 0-19
// - settings kept in flash, rewrite per write
// - restore jumper at power-up zeroes settings
`include "usb_command_watchdog_map.vh"
`timescale 1ns/1ps
module usb_command_watchdog #(
  parameter integer TICK_DIVIDE = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire ref_clk,
  input wire srst,
  input wire hostTransfer,
  input wire streamPacketOut,
  input wire cmdValid,
  input wire [7:0] cmdByte,
  input wire cmdLast,
  output reg replyValid,
  output reg [7:0] replyByte,
  output reg replyLast,
  input wire restoreJumper,
  output reg [31:0] flashData,
  output reg flashWrite,
  input wire flashDone,
  input wire [31:0] flashStored,
  output reg deviceReset,
  output reg [`LINE_COUNT-1:0] lineDrive,
  output reg [`LINE_COUNT-1:0] lineLevel,
  output wire [15:0] wdCount,
  output wire wdRunning
);
  localparam [2:0] ST_LOAD = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_FLASH = 3'h2;
  localparam [2:0] ST_REPLY = 3'h3;
  localparam [2:0] ST_ERASE = 3'h4;

  reg [2:0] state_reg;
  reg [7:0] options_reg;
  reg [15:0] limit_reg;
  reg [7:0] lineCfg_reg;
  reg [15:0] count_reg;
  reg [7:0] buf_reg [0:`CMD_LENGTH-1];
  reg [4:0] idx_reg;
  reg [7:0] err_reg;
  reg hostSync1_reg;
  reg hostSync2_reg;
  reg hostSync3_reg;
  reg jumpSync1_reg;
  reg jumpSync2_reg;
  reg [15:0] headSum;
  reg [15:0] bodySum;
  wire tick;
  wire hostPulse;
  wire headerOk;
  wire doWrite;
  wire [15:0] replyTotal;
  integer i;
  integer k;

  function [7:0] fold8;
    input [15:0] s;
    reg [8:0] t;
    begin
      t = {1'b0, s[7:0]} + {1'b0, s[15:8]};
      fold8 = t[7:0] + {7'h00, t[8]};
    end
  endfunction

  // host pulse resynchronised, then edge detected on the second stage
  always @(posedge ref_clk)
  begin
    hostSync1_reg <= hostTransfer;
    hostSync2_reg <= hostSync1_reg;
    hostSync3_reg <= hostSync2_reg;
    jumpSync1_reg <= restoreJumper;
    jumpSync2_reg <= jumpSync1_reg;
  end
  // outgoing stream traffic is deliberately not observed here
  assign hostPulse = hostSync2_reg & ~hostSync3_reg;

  assign wdRunning = (options_reg != 8'h00);
  assign wdCount = count_reg;

  second_tick #(
    .DIVIDE(TICK_DIVIDE)
  ) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .clear(hostPulse | ~wdRunning),
    .tick(tick)
  );

  always @(posedge ref_clk)
  begin
    if (srst || !wdRunning || hostPulse)
      count_reg <= 16'h0000;
    else if (tick && count_reg != limit_reg)
      count_reg <= count_reg + 16'h0001;
  end

  // expiry actions, one-shot on reaching the limit
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      deviceReset <= 1'b0;
      lineDrive <= {`LINE_COUNT{1'b0}};
      lineLevel <= {`LINE_COUNT{1'b0}};
    end
    else
    begin
      deviceReset <= 1'b0;
      if (wdRunning && tick && count_reg + 16'h0001 == limit_reg)
      begin
        deviceReset <= options_reg[`BIT_OPT_RESET];
        if (options_reg[`BIT_OPT_LINE] &&
            lineCfg_reg[`LINE_INDEX_MSB:0] <= `LINE_INDEX_MAX)
        begin
          lineDrive[lineCfg_reg[`LINE_INDEX_MSB:0]] <= 1'b1;
          lineLevel[lineCfg_reg[`LINE_INDEX_MSB:0]] <= lineCfg_reg[`BIT_LINE_LEVEL];
        end
      end
    end
  end

  // sums over the buffer in one process so every stored byte wakes it
  always @*
  begin
    headSum = 16'h0000;
    bodySum = 16'h0000;
    for (k = 1; k < `CMD_LENGTH; k = k + 1)
    begin
      if (k < `POS_UPDATE_SELECT)
        headSum = headSum + {8'h00, buf_reg[k]};
      else
        bodySum = bodySum + {8'h00, buf_reg[k]};
    end
  end

  assign headerOk = buf_reg[`POS_SYNC] == `CMD_SYNC_BYTE &&
    buf_reg[`POS_WORDS] == `CMD_WORD_COUNT && buf_reg[`POS_EXT] == `CMD_EXT_CODE &&
    buf_reg[`POS_HEADER_SUM] == fold8(headSum) &&
    {buf_reg[`POS_BODY_HI], buf_reg[`POS_BODY_LO]} == bodySum;
  assign replyTotal = {8'h00, err_reg} + {8'h00, options_reg} + {8'h00, limit_reg[7:0]} +
    {8'h00, limit_reg[15:8]} + {8'h00, lineCfg_reg};
  assign doWrite = buf_reg[`POS_UPDATE_SELECT][`BIT_UPDATE_WRITE];

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_LOAD;
      options_reg <= 8'h00;
      limit_reg <= 16'h0000;
      lineCfg_reg <= 8'h00;
      idx_reg <= 5'h00;
      err_reg <= `ERR_NONE;
      flashData <= `SETTINGS_RESET;
      flashWrite <= 1'b0;
      replyValid <= 1'b0;
      replyByte <= 8'h00;
      replyLast <= 1'b0;
      for (i = 0; i < `CMD_LENGTH; i = i + 1)
        buf_reg[i] <= 8'h00;
    end
    else
    begin
      flashWrite <= 1'b0;
      replyValid <= 1'b0;
      replyLast <= 1'b0;
      case (state_reg)
        ST_LOAD:
        begin
          if (jumpSync2_reg)
          begin
            flashData <= `SETTINGS_RESET;
            flashWrite <= 1'b1;
            state_reg <= ST_ERASE;
          end
          else
          begin
            {lineCfg_reg, limit_reg, options_reg} <= flashStored;
            state_reg <= ST_IDLE;
          end
        end
        ST_ERASE:
          if (flashDone)
            state_reg <= ST_IDLE;
        ST_IDLE:
          if (cmdValid)
          begin
            if (idx_reg < `CMD_LENGTH)
            begin
              buf_reg[idx_reg[3:0]] <= cmdByte;
              idx_reg <= idx_reg + 5'h01;
            end
            if (cmdLast)
            begin
              idx_reg <= 5'h00;
              state_reg <= ST_FLASH;
            end
          end
        ST_FLASH:
        begin
          // decide, store and prepare the reply
          idx_reg <= 5'h00;
          err_reg <= `ERR_NONE;
          if (!headerOk)
          begin
            err_reg <= `ERR_BAD_LINE;
            state_reg <= ST_REPLY;
          end
          else if (doWrite)
          begin
            options_reg <= buf_reg[`POS_OPTIONS];
            limit_reg <= {buf_reg[`POS_LIMIT_HI], buf_reg[`POS_LIMIT_LO]};
            lineCfg_reg <= buf_reg[`POS_LINE_CFG];
            flashData <= {buf_reg[`POS_LINE_CFG], buf_reg[`POS_LIMIT_HI],
              buf_reg[`POS_LIMIT_LO], buf_reg[`POS_OPTIONS]};
            flashWrite <= 1'b1;
            state_reg <= ST_REPLY;
          end
          else
            state_reg <= ST_REPLY;
        end
        ST_REPLY:
        begin
          replyValid <= 1'b1;
          case (idx_reg)
            5'd0: replyByte <= fold8({8'h00, `CMD_SYNC_BYTE} + {8'h00, `CMD_WORD_COUNT} +
              {8'h00, `CMD_EXT_CODE} + {8'h00, replyTotal[7:0]} + {8'h00, replyTotal[15:8]});
            5'd1: replyByte <= `CMD_SYNC_BYTE;
            5'd2: replyByte <= `CMD_WORD_COUNT;
            5'd3: replyByte <= `CMD_EXT_CODE;
            5'd4: replyByte <= replyTotal[7:0];
            5'd5: replyByte <= replyTotal[15:8];
            5'd6: replyByte <= err_reg;
            5'd7: replyByte <= options_reg;
            5'd8: replyByte <= limit_reg[7:0];
            5'd9: replyByte <= limit_reg[15:8];
            5'd10: replyByte <= lineCfg_reg;
            default: replyByte <= 8'h00;
          endcase
          idx_reg <= idx_reg + 5'h01;
          if (idx_reg == `CMD_LENGTH - 1)
          begin
            replyLast <= 1'b1;
            idx_reg <= 5'h00;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // usb_command_watchdog

/* dv/usb_command_watchdog_chk.sv */
// assertion checker for the usb command watchdog
`timescale 1ns/1ps
module usb_command_watchdog_chk (
  input wire ref_clk,
  input wire srst,
  input wire hostTransfer,
  input wire cmdValid,
  input wire replyValid,
  input wire [7:0] replyByte,
  input wire replyLast,
  input wire deviceReset,
  input wire [19:0] lineDrive,
  input wire [15:0] wdCount,
  input wire wdRunning
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_byte8; replyValid [*8]; endsequence
  sequence s_hdr; replyByte == 8'hF8 ##1 replyByte == 8'h05 ##1 replyByte == 8'h09; endsequence
  sequence s_quiet; (!hostTransfer && !cmdValid) [*5]; endsequence
  property p_hold; !wdRunning |=> wdCount == 16'h0; endproperty
  property p_step; $changed(wdCount) |-> wdCount == $past(wdCount) + 16'h1 || wdCount == 16'h0;
  endproperty
  property p_quiet; s_quiet ##0 wdCount != 16'h0 |=> wdCount != 16'h0; endproperty
  property p_clear; $rose(hostTransfer) ##1 hostTransfer [*2] |-> ##[1:5] wdCount == 16'h0;
  endproperty
  property p_pulse; deviceReset |=> !deviceReset; endproperty
  property p_fire; deviceReset || $changed(lineDrive) |-> wdRunning && wdCount != 16'h0; endproperty
  property p_sticky; (lineDrive & $past(lineDrive)) == $past(lineDrive); endproperty
  property p_len; $rose(replyValid) |-> s_byte8 ##1 s_byte8 ##0 replyLast; endproperty
  property p_hdr; $rose(replyValid) |=> s_hdr; endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");
  a_step: assert property (p_step) else $error("count jumped");
  a_quiet: assert property (p_quiet) else $error("count cleared without host traffic");
  a_clear: assert property (p_clear) else $error("host traffic did not clear count");
  a_pulse: assert property (p_pulse) else $error("device reset longer than a cycle");
  a_fire: assert property (p_fire) else $error("action without expiry");
  a_sticky: assert property (p_sticky) else $error("driven line released");
  a_len: assert property (p_len) else $error("reply not sixteen bytes");
  a_hdr: assert property (p_hdr) else $error("reply header wrong");
endmodule // usb_command_watchdog_chk
bind usb_command_watchdog usb_command_watchdog_chk u_chk (.ref_clk(ref_clk), .srst(srst),
  .hostTransfer(hostTransfer), .cmdValid(cmdValid), .replyValid(replyValid),
  .replyByte(replyByte), .replyLast(replyLast), .deviceReset(deviceReset),
  .lineDrive(lineDrive), .wdCount(wdCount), .wdRunning(wdRunning));

/* dv/host_model.sv */
// host side model: sends command packets and bare host transfers
`timescale 1ns/1ps
module host_model (
  input wire ref_clk,
  output reg hostTransfer = 1'b0,
  output reg cmdValid = 1'b0,
  output reg [7:0] cmdByte = 8'h00,
  output reg cmdLast = 1'b0
);
  task send(input [127:0] pkt);
    integer i;
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge ref_clk);
      hostTransfer <= (i < 3);
      cmdValid <= 1'b1;
      cmdByte <= pkt[8*i +: 8];
      cmdLast <= (i == 15);
    end
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    cmdLast <= 1'b0;
    cmdByte <= ~cmdByte;
  endtask
  task ping;
    @(posedge ref_clk);
    hostTransfer <= 1'b1;
    repeat (3) @(posedge ref_clk);
    hostTransfer <= 1'b0;
  endtask
endmodule // host_model

/* dv/testbench.sv */
// self-checking bench for the usb command watchdog
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg streamPacketOut = 1'b0;
  reg restoreJumper = 1'b0;
  reg flashDone = 1'b0;
  reg [31:0] flashStored = 32'h0;
  reg streamOn = 1'b0;
  wire hostTransfer, cmdValid, cmdLast, replyValid, replyLast, flashWrite, deviceReset, wdRunning;
  wire [7:0] cmdByte, replyByte;
  wire [31:0] flashData;
  wire [19:0] lineDrive, lineLevel;
  wire [15:0] wdCount;
  reg [7:0] rx [0:15];
  reg [31:0] fwData;
  reg [7:0] cfg;
  integer nrx = 0, nfw = 0, nrst = 0, n_mismatch = 0, comparisons = 0, j;
  integer nrstBase = 0;
  always #50 ref_clk = ~ref_clk;
  host_model u_host (.ref_clk(ref_clk), .hostTransfer(hostTransfer), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .cmdLast(cmdLast));
  usb_command_watchdog #(.TICK_DIVIDE(4)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .hostTransfer(hostTransfer), .streamPacketOut(streamPacketOut), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .cmdLast(cmdLast), .replyValid(replyValid), .replyByte(replyByte),
    .replyLast(replyLast), .restoreJumper(restoreJumper), .flashData(flashData),
    .flashWrite(flashWrite), .flashDone(flashDone), .flashStored(flashStored),
    .deviceReset(deviceReset), .lineDrive(lineDrive), .lineLevel(lineLevel),
    .wdCount(wdCount), .wdRunning(wdRunning));
  always @(posedge ref_clk)
  begin
    streamPacketOut <= streamOn && ($urandom % 2);
    if (replyValid)
    begin
      rx[nrx % 16] <= replyByte;
      nrx <= nrx + 1;
    end
    if (flashWrite)
    begin
      nfw <= nfw + 1;
      fwData <= flashData;
    end
    if (deviceReset)
      nrst <= nrst + 1;
  end
  // packet with both sums; a reply has the same layout with the result in byte 6
  function [127:0] mkcmd(input [7:0] wr, input [7:0] opt, input [15:0] lim, input [7:0] lc,
    input [7:0] sync);
    reg [127:0] p;
    reg [15:0] s;
    integer i;
    p = {40'h0, lc, lim, opt, wr, 16'h0, 8'h09, 8'h05, sync, 8'h00};
    s = 16'h0;
    for (i = 6; i < 16; i = i + 1)
      s = s + p[8*i +: 8];
    p[47:32] = s;
    s = 16'h0;
    for (i = 1; i < 6; i = i + 1)
      s = s + p[8*i +: 8];
    s = s[7:0] + s[15:8];
    s = s[7:0] + s[15:8];
    p[7:0] = s[7:0];
    mkcmd = p;
  endfunction
  task check(input string name, input [127:0] exp, input [127:0] act);
    comparisons = comparisons + 1;
    if (exp !== act)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %0h seen %0h", name, exp, act);
    end
  endtask
  task xact(input [127:0] cmd, input [127:0] exp);
    integer i;
    reg [127:0] got;
    nrx = 0;
    u_host.send(cmd);
    for (i = 0; i < 40 && nrx < 16; i = i + 1)
      @(posedge ref_clk);
    @(negedge ref_clk);
    for (i = 0; i < 16; i = i + 1)
      got[8*i +: 8] = rx[i];
    check("reply", exp, got);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // roughly five times the length of the whole sequence
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial
  begin
    j = $urandom(77750);
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (24) @(posedge ref_clk);
    check("idle", 17'h0, {wdRunning, wdCount});
    $display("test idle done");
    // chosen line is taken to be an output already
    cfg = {3'b100, 5'($urandom % 20)};
    xact(mkcmd(8'h01, 8'h30, 16'h3, cfg, 8'hF8), mkcmd(8'h00, 8'h30, 16'h3, cfg, 8'hF8));
    check("flash", {cfg, 24'h000330}, fwData);
    repeat (30) @(posedge ref_clk);
    check("expiry", {1'b1, 20'h1 << cfg[4:0], 1'b1, 16'h3},
      {nrst == 1, lineDrive, lineLevel[cfg[4:0]], wdCount});
    $display("test expiry done");
    cfg = 8'h02;
    xact(mkcmd(8'h01, 8'h10, 16'h100, cfg, 8'hF8), mkcmd(8'h00, 8'h10, 16'h100, cfg, 8'hF8));
    streamOn <= 1'b1;
    repeat (30) @(posedge ref_clk);
    check("counting", 1'b1, wdCount > 16'h4);
    u_host.ping;
    repeat (2) @(posedge ref_clk);
    check("cleared", 1'b1, wdCount < 16'h2);
    streamOn <= 1'b0;
    $display("test clear done");
    nfw = 0;
    xact(mkcmd(8'($urandom) & 8'hFE, 8'($urandom), 16'($urandom), 8'($urandom), 8'hF8),
      mkcmd(8'h00, 8'h10, 16'h100, cfg, 8'hF8));
    xact(mkcmd(8'h01, 8'h30, 16'h5, cfg, 8'hF7), mkcmd(8'h01, 8'h10, 16'h100, cfg, 8'hF8));
    check("noWrite", 0, nfw);
    $display("test read done");
    for (j = 1; j >= 0; j = j - 1)
    begin
      @(posedge ref_clk);
      nrstBase = nrst;
      restoreJumper <= j[0];
      flashStored <= 32'h85000720;
      srst <= 1'b1;
      nfw = 0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      if (j == 1)
        check("restore", 33'h1_0000_0000, {nfw == 1, fwData});
      flashDone <= 1'b1;
      @(posedge ref_clk);
      flashDone <= 1'b0;
      repeat (2) @(posedge ref_clk);
      xact(mkcmd(8'h00, 8'h00, 16'h0, 8'h00, 8'hF8), (j == 1) ? mkcmd(8'h00, 8'h00, 16'h0, 8'h00,
        8'hF8) : mkcmd(8'h00, 8'h20, 16'h7, 8'h85, 8'hF8));
      if (j == 0)
      begin
        repeat (40) @(posedge ref_clk);
        check("resetOnly", {1'b1, 20'h0_0000}, {nrst == nrstBase + 1, lineDrive});
      end
    end
    $display("test power-up done");
    test_done;
  end
endmodule // testbench
